// ===== shared/mctcsr_map.vh
`ifndef MCTCSR_MAP_VH
`define MCTCSR_MAP_VH
// Register indexes on the csr port (the hart's own numbering, chosen here)
`define MCT_IDX_CYCLE      6'h00
`define MCT_IDX_INSTR      6'h01
`define MCT_IDX_CYCLE_UP   6'h02
`define MCT_IDX_INSTR_UP   6'h03
`define MCT_IDX_HEN        6'h04
`define MCT_IDX_SEN        6'h05
`define MCT_IDX_UEN        6'h06
`define MCT_IDX_SCRATCH    6'h07
`define MCT_IDX_EPC        6'h08
`define MCT_IDX_CAUSE      6'h09
`define MCT_IDX_BADADDR    6'h0A
// Offsets: base + level*3 + kind (level 0 hyp,1 sup,2 usr; kind 0 cycle,1 time,2 retired)
`define MCT_IDX_OFS_BASE   6'h10
`define MCT_IDX_OFSUP_BASE 6'h20
// Lower-privilege counter reads: base + level*3 + kind
`define MCT_IDX_LOW_BASE   6'h30
`define MCT_NUM_OFS        9
// Counter-enable bit positions
`define MCT_BIT_CY         0
`define MCT_BIT_TM         1
`define MCT_BIT_IR         2
`define MCT_EN_W           3
// Cause codes
`define MCT_CAUSE_ILLEGAL  6'h02
`define MCT_CAUSE_W        6
`define MCT_CAUSE_MAX      6'h0B
`endif

// ===== rtl/mct_csr_bank.v
// Functional notes
// - Cycle counter advances every hart cycle
// - Retired counter advances per retired instruction
// - Both counters are 64 bits wide
// - Narrow hart: low half, upper-half registers
// - Wide hart: counter reads sign-extended
// - Hypervisor enable bits gate counter reads
// - Supervisor, user enables use same bits
// - Enable registers exist, bits may be tied
// - Lower counter read adds delta register
// - Nine 64-bit delta registers, tie-able
// - Narrow hart: delta upper-half aliases
// - Scratch register freely read and written
// - Return address never misaligned
// - Trap loads faulting instruction address
// - Cause top bit marks interrupt
// - Cause code keeps supported codes only
// - Interrupt codes 0 to 11
// - Exception codes 0 to 11
// - Privilege violation uses illegal code
// - Fault address loaded on address faults
// - Fetch fault: part address, start pc
`timescale 1ns/10ps
`include "mctcsr_map.vh"
module mct_csr_bank #(
  parameter XW        = 64,
  parameter HAS_C16   = 1,
  parameter EN_MASK   = 3'h7,
  parameter OFS_IMPL  = 9'h1FF
) (
  input  wire          clk,
  input  wire          reset,
  input  wire          csr_rd,
  input  wire          csr_wr,
  input  wire [5:0]    csr_idx,
  input  wire [XW-1:0] csr_wdata,
  output reg  [XW-1:0] csr_rdata,
  output wire          csr_illegal,
  input  wire [1:0]    priv_mode,
  input  wire [63:0]   time_value,
  input  wire          instr_retire,
  input  wire          trap_take,
  input  wire          trap_is_irq,
  input  wire [5:0]    trap_code,
  input  wire [XW-1:0] trap_pc,
  input  wire          trap_addr_valid,
  input  wire [XW-1:0] trap_addr
);
  localparam PRIV_M = 2'h3;
  localparam NARROW = (XW == 32);
  reg  [63:0]   cyc_r;
  reg  [63:0]   ins_r;
  reg  [63:0]   cyc_nxt;
  reg  [63:0]   ins_nxt;
  reg  [2:0]    en_r [0:2];
  reg  [63:0]   ofs_r [0:`MCT_NUM_OFS-1];
  reg  [XW-1:0] scratch_r;
  reg  [XW-1:0] epc_r;
  reg           irq_r;
  reg  [`MCT_CAUSE_W-1:0] code_r;
  reg  [XW-1:0] bad_r;
  reg  [XW-1:0] rd_nxt;
  reg           ill_nxt;
  reg  [63:0]   low_sum;
  reg  [63:0]   base_cnt;
  wire [XW-1:0] align_mask = HAS_C16 ? {{(XW-1){1'b1}}, 1'b0} : {{(XW-2){1'b1}}, 2'h0};
  wire          wr_ok = csr_wr && priv_mode == PRIV_M;
  wire [5:0]    low_rel = csr_idx - `MCT_IDX_LOW_BASE;
  wire [5:0]    ofs_rel = csr_idx - `MCT_IDX_OFS_BASE;
  wire [5:0]    ofu_rel = csr_idx - `MCT_IDX_OFSUP_BASE;
  wire          low_hit = csr_idx >= `MCT_IDX_LOW_BASE && low_rel < `MCT_NUM_OFS;
  wire [1:0]    low_lvl = (low_rel >= 6'h06) ? 2'h2 : (low_rel >= 6'h03) ? 2'h1 : 2'h0;
  wire [1:0]    low_kind = low_rel[1:0] - (low_lvl == 2'h2 ? 2'h0 : low_lvl == 2'h1 ? 2'h3 : 2'h0)
                           + (low_lvl == 2'h2 ? 2'h2 : 2'h0);
  // Sign extension to the native width, narrow hart keeps the low half
  function [XW-1:0] widen;
    input [63:0]    v;
    reg   [XW+63:0] ext;
    begin
      ext   = {{XW{v[63]}}, v};
      widen = ext[XW-1:0];
    end
  endfunction
  // Write data cut or zero-extended to counter width; bits above bit 63 are dropped silently
  function [63:0] narrow;
    input [XW-1:0]  w;
    reg   [XW+63:0] ext;
    begin
      ext    = {{64{1'b0}}, w};
      narrow = ext[63:0];
    end
  endfunction
  // Counter hardware: a software write in the same cycle takes precedence over the increment
  always @* begin
    cyc_nxt = cyc_r + 64'h1;
    ins_nxt = instr_retire ? ins_r + 64'h1 : ins_r;
    if (wr_ok && csr_idx == `MCT_IDX_CYCLE)
      cyc_nxt = NARROW ? {cyc_r[63:32], csr_wdata[31:0]} : narrow(csr_wdata);
    if (wr_ok && NARROW && csr_idx == `MCT_IDX_CYCLE_UP)
      cyc_nxt = {csr_wdata[31:0], cyc_r[31:0]};
    if (wr_ok && csr_idx == `MCT_IDX_INSTR)
      ins_nxt = NARROW ? {ins_r[63:32], csr_wdata[31:0]} : narrow(csr_wdata);
    if (wr_ok && NARROW && csr_idx == `MCT_IDX_INSTR_UP)
      ins_nxt = {csr_wdata[31:0], ins_r[31:0]};
  end
  always @(posedge clk) begin
    if (reset) begin
      cyc_r <= 64'h0;
      ins_r <= 64'h0;
    end else begin
      cyc_r <= cyc_nxt;
      ins_r <= ins_nxt;
    end
  end
  // Enable and delta registers; unimplemented bits tie to zero
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_en
      always @(posedge clk) begin
        if (reset)
          en_r[g] <= 3'h0;
        else if (wr_ok && csr_idx == `MCT_IDX_HEN + g)
          en_r[g] <= csr_wdata[2:0] & EN_MASK;
      end
    end
    for (g = 0; g < `MCT_NUM_OFS; g = g + 1) begin : g_ofs
      always @(posedge clk) begin
        if (reset || !OFS_IMPL[g])
          ofs_r[g] <= 64'h0;
        else if (wr_ok && csr_idx == `MCT_IDX_OFS_BASE + g)
          ofs_r[g] <= NARROW ? {ofs_r[g][63:32], csr_wdata[31:0]} : narrow(csr_wdata);
        else if (wr_ok && NARROW && csr_idx == `MCT_IDX_OFSUP_BASE + g)
          ofs_r[g] <= {csr_wdata[31:0], ofs_r[g][31:0]};
      end
    end
  endgenerate
  // Scratch and trap state; trap capture outranks a software write in the same cycle
  always @(posedge clk) begin
    if (reset) begin
      scratch_r <= {XW{1'b0}};
      epc_r     <= {XW{1'b0}};
      irq_r     <= 1'b0;
      code_r    <= {`MCT_CAUSE_W{1'b0}};
      bad_r     <= {XW{1'b0}};
    end else begin
      if (wr_ok && csr_idx == `MCT_IDX_SCRATCH)
        scratch_r <= csr_wdata;
      if (trap_take) begin
        epc_r  <= trap_pc & align_mask;
        irq_r  <= trap_is_irq;
        code_r <= (trap_code > `MCT_CAUSE_MAX) ? `MCT_CAUSE_ILLEGAL : trap_code;
        if (trap_addr_valid && !trap_is_irq)
          bad_r <= trap_addr;
      end else if (wr_ok) begin
        if (csr_idx == `MCT_IDX_EPC)
          epc_r <= csr_wdata & align_mask;
        if (csr_idx == `MCT_IDX_CAUSE) begin
          irq_r <= csr_wdata[XW-1];
          if (csr_wdata[`MCT_CAUSE_W-1:0] <= `MCT_CAUSE_MAX)
            code_r <= csr_wdata[`MCT_CAUSE_W-1:0];
        end
        if (csr_idx == `MCT_IDX_BADADDR)
          bad_r <= csr_wdata;
      end
    end
  end
  // Read side: access check and lower-privilege sums are combinational, data is registered
  always @* begin
    rd_nxt   = {XW{1'b0}};
    ill_nxt  = 1'b0;
    base_cnt = (low_kind == 2'h0) ? cyc_r : (low_kind == 2'h1) ? time_value : ins_r;
    low_sum  = base_cnt + ofs_r[low_rel[3:0]];
    if (low_hit) begin
      if (!en_r[low_lvl][low_kind] && priv_mode != PRIV_M)
        ill_nxt = 1'b1;
      else
        rd_nxt = widen(low_sum);
    end else if (csr_idx >= `MCT_IDX_OFS_BASE && ofs_rel < `MCT_NUM_OFS) begin
      rd_nxt = widen(ofs_r[ofs_rel[3:0]]);
    end else if (NARROW && csr_idx >= `MCT_IDX_OFSUP_BASE && ofu_rel < `MCT_NUM_OFS) begin
      rd_nxt = widen({32'h0, ofs_r[ofu_rel[3:0]][63:32]});
    end else begin
      case (csr_idx)
        `MCT_IDX_CYCLE:    rd_nxt = widen(cyc_r);
        `MCT_IDX_INSTR:    rd_nxt = widen(ins_r);
        `MCT_IDX_CYCLE_UP: rd_nxt = NARROW ? widen({32'h0, cyc_r[63:32]}) : {XW{1'b0}};
        `MCT_IDX_INSTR_UP: rd_nxt = NARROW ? widen({32'h0, ins_r[63:32]}) : {XW{1'b0}};
        `MCT_IDX_HEN:      rd_nxt = {{(XW-3){1'b0}}, en_r[0]};
        `MCT_IDX_SEN:      rd_nxt = {{(XW-3){1'b0}}, en_r[1]};
        `MCT_IDX_UEN:      rd_nxt = {{(XW-3){1'b0}}, en_r[2]};
        `MCT_IDX_SCRATCH:  rd_nxt = scratch_r;
        `MCT_IDX_EPC:      rd_nxt = epc_r & align_mask;
        `MCT_IDX_CAUSE:    rd_nxt = {irq_r, {(XW-1-`MCT_CAUSE_W){1'b0}}, code_r};
        `MCT_IDX_BADADDR:  rd_nxt = bad_r;
        default:           rd_nxt = {XW{1'b0}};
      endcase
    end
  end
  assign csr_illegal = csr_rd && ill_nxt;
  always @(posedge clk) begin
    if (reset)
      csr_rdata <= {XW{1'b0}};
    else if (csr_rd)
      csr_rdata <= rd_nxt;
  end
endmodule

// ===== sim/mct_csr_bank_monitor.sv
`timescale 1ns/10ps
`include "mctcsr_map.vh"
module mct_csr_bank_monitor #(parameter XW = 64) (
  input wire          clk,
  input wire          reset,
  input wire          csr_rd,
  input wire          csr_wr,
  input wire [5:0]    csr_idx,
  input wire [XW-1:0] csr_wdata,
  input wire [XW-1:0] csr_rdata,
  input wire          csr_illegal,
  input wire [1:0]    priv_mode,
  input wire [63:0]   time_value,
  input wire          instr_retire,
  input wire          trap_take,
  input wire          trap_is_irq,
  input wire [5:0]    trap_code,
  input wire [XW-1:0] trap_pc,
  input wire          trap_addr_valid,
  input wire [XW-1:0] trap_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // A trap in the same cycle updates the trap registers only after the read has captured their old values
  wire rd_ok  = csr_rd && !csr_wr && !trap_take;
  wire rd_cyc = rd_ok && csr_idx == `MCT_IDX_CYCLE;
  wire rd_ins = rd_ok && csr_idx == `MCT_IDX_INSTR;
  wire rd_epc = rd_ok && csr_idx == `MCT_IDX_EPC;
  wire flt    = trap_take && trap_addr_valid && !trap_is_irq;
  m_no_trap_a: assert property (csr_rd && priv_mode == 2'h3 |-> !csr_illegal)
    else $error("machine read trapped");
  trap_on_read_a: assert property (csr_illegal |-> csr_rd && csr_idx >= `MCT_IDX_LOW_BASE)
    else $error("illegal without lower read");
  cycle_step_a: assert property (rd_cyc ##1 rd_cyc |=> csr_rdata == $past(csr_rdata) + 1)
    else $error("cycle step");
  retire_step_a: assert property (rd_ins ##1 rd_ins |=> csr_rdata == $past(csr_rdata) + $past(instr_retire, 2))
    else $error("retire step");
  epc_low_a: assert property (rd_epc |=> !csr_rdata[0])
    else $error("epc bit0");
  cause_irq_a: assert property (trap_take ##1 (rd_ok && csr_idx == `MCT_IDX_CAUSE) |=>
    csr_rdata[XW-1] == $past(trap_is_irq, 2)) else $error("cause flag");
  epc_load_a: assert property (trap_take ##1 rd_epc |=> csr_rdata >> 1 == $past(trap_pc, 2) >> 1)
    else $error("epc load");
  badaddr_load_a: assert property (flt ##1 (rd_ok && csr_idx == `MCT_IDX_BADADDR) |=>
    csr_rdata == $past(trap_addr, 2)) else $error("badaddr load");
  cover property (csr_illegal);
  cover property (rd_cyc ##1 rd_cyc);
  cover property (trap_take && trap_is_irq);
endmodule
bind mct_csr_bank mct_csr_bank_monitor #(.XW(XW)) u_mon (.*);

// ===== sim/mct_hart_model.sv
`timescale 1ns/10ps
module mct_hart_model (
  input  wire        clk,
  input  wire        run,
  output reg         instr_retire = 1'b0,
  output reg  [63:0] time_value   = 64'h0000_0000_0000_1000
);
  // Alternate-cycle retirement keeps the retired count visibly apart from cycles
  always @(negedge clk) begin
    instr_retire <= run && !instr_retire;
    if (run) time_value <= time_value + 64'h1;
  end
endmodule

// ===== sim/test_machine_counter_trap_csrs.sv
`timescale 1ns/10ps
`include "mctcsr_map.vh"
module test_machine_counter_trap_csrs;
  reg         clk = 0, reset = 1, run = 0, csr_rd = 0, csr_wr = 0, f;
  reg         trap_take = 0, trap_is_irq = 0, trap_addr_valid = 0, av;
  reg  [1:0]  priv_mode = 3;
  reg  [5:0]  csr_idx = 0, trap_code = 0, q, j, cc;
  reg  [63:0] csr_wdata = 0, trap_pc = 0, trap_addr = 0, d, e, ba = 0;
  wire [63:0] csr_rdata, time_value;
  wire        csr_illegal, instr_retire;
  int         bad_count = 0, tests_run = 0;
  mct_csr_bank u_dut (.clk(clk), .reset(reset), .csr_rd(csr_rd), .csr_wr(csr_wr), .csr_idx(csr_idx),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_illegal(csr_illegal), .priv_mode(priv_mode),
    .time_value(time_value), .instr_retire(instr_retire), .trap_take(trap_take), .trap_is_irq(trap_is_irq),
    .trap_code(trap_code), .trap_pc(trap_pc), .trap_addr_valid(trap_addr_valid), .trap_addr(trap_addr));
  mct_hart_model u_hart (.clk(clk), .run(run), .instr_retire(instr_retire), .time_value(time_value));
  initial forever #4 clk = !clk;
  // Entered at a falling edge; leaves the request up so reads can run back to back
  task automatic op(input w, input [1:0] pm, input [5:0] i, input [63:0] wd, output [63:0] rd, output il);
    csr_wr = w; csr_rd = !w; priv_mode = pm; csr_idx = i; csr_wdata = wd;
    #1 il = csr_illegal;
    @(negedge clk) rd = csr_rdata;
  endtask
  task automatic trap(input i, input [5:0] c, input v, input [63:0] p, input [63:0] a);
    csr_rd = 0; csr_wr = 0; trap_take = 1; trap_is_irq = i; trap_code = c; trap_addr_valid = v;
    trap_pc = p; trap_addr = a;
    @(negedge clk) trap_take = 0;
  endtask
  task automatic chk(input string n, input [63:0] x, input [63:0] g);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk1(input string n, input x, input g);
    chk(n, {63'h0, x}, {63'h0, g});
  endtask
  task report_and_stop;
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000 bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(negedge clk);
    reset = 0;
    op(0, 3, `MCT_IDX_SCRATCH, 0, d, f); chk("scratch_reset", 0, d);
    op(1, 3, `MCT_IDX_SCRATCH, 64'hA5A5_0000_FFFF_1234, d, f);
    op(1, 0, `MCT_IDX_SCRATCH, 0, d, f);
    op(0, 3, `MCT_IDX_SCRATCH, 0, d, f); chk("scratch", 64'hA5A5_0000_FFFF_1234, d);
    op(1, 3, `MCT_IDX_CYCLE, '1, d, f);
    op(0, 3, `MCT_IDX_CYCLE, 0, d, f); chk("cycle_top", '1, d);
    op(0, 3, `MCT_IDX_CYCLE, 0, d, f); chk("cycle_wrap", 0, d);
    op(1, 3, `MCT_IDX_INSTR, 64'h10, d, f);
    op(0, 3, `MCT_IDX_INSTR, 0, d, f); chk("retired_idle", 64'h10, d);
    run <= 1;
    for (q = 0; q < 3; q++) op(0, 3, `MCT_IDX_INSTR, 0, d, f);
    for (q = 0; q < 9; q++) begin
      op(0, 0, 6'h30 + q, 0, d, f); chk1("deny", 1, f);
      op(1, 3, 6'h04 + q / 3, 64'h1 << q % 3, d, f);
      op(0, 3, 6'h04 + q / 3, 0, d, f); chk("enable", 64'h1 << q % 3, d);
      op(0, 0, 6'h30 + q, 0, d, f); chk1("allow", 0, f);
      op(1, 3, 6'h04 + q / 3, 0, d, f);
    end
    run <= 0;
    for (q = 0; q < 26; q++) for (j = 0; j < 3; j++) begin
      cc = q % 6'h0D;
      // Only misaligned or access faults on fetch, load and store carry an address
      av = q < 6'h0D && (cc < 6'h02 || (cc > 6'h03 && cc < 6'h08));
      trap(q > 6'h0C, cc, av, 64'h8000_0000_0000_1001 + q * 4, {58'h0, q});
      if (av) ba = {58'h0, q};
      op(0, 3, 6'h09 - j[0] + j[1], 0, d, f);
      e = j == 0 ? {q > 6'h0C, 57'h0, (cc > 6'h0B) ? 6'h02 : cc} : j == 1 ? 64'h8000_0000_0000_1000 + q * 4 : ba;
      chk("trap_state", e, d);
    end
    op(1, 3, 6'h17, 64'h100, d, f);
    op(0, 3, 6'h37, 0, d, f); chk("usr_time", time_value + 64'h100, d);
    report_and_stop;
  end
endmodule
